//--- rtl/dmb_col_order.sv
/*
 * Column offset within an eight-column block for one burst beat.
 * Purely combinational; assumes beat and start are stable in the cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module dmb_col_order (
    input  wire logic [2:0] start_col,
    input  wire logic [2:0] beat,
    input  wire logic       interleave,
    input  wire logic       is_write,
    input  wire logic       chop,
    output logic      [2:0] col
);
    wire [2:0] wr_col;
    wire [2:0] seq_col;
    wire [2:0] ilv_col;
    wire [1:0] low_sum;

    // writes ignore the low start bits entirely
    assign wr_col  = chop ? {start_col[2], beat[1:0]} : beat;
    assign low_sum = start_col[1:0] + beat[1:0];
    // sequential wraps in a nibble, then moves to the other nibble
    assign seq_col = {start_col[2] ^ beat[2], low_sum};
    assign ilv_col = start_col ^ beat;
    assign col     = is_write ? wr_col : (interleave ? ilv_col : seq_col);
endmodule
`default_nettype wire

//--- rtl/dmb_defs.svh
/*
 * Constants for the base mode register block: field positions, encodings,
 * reset values and the DLL lock count.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef DMB_DEFS_SVH
`define DMB_DEFS_SVH

// Summary of operation
// - mode bits 1:0 pick fixed eight, chop four or per-command length.
// - on-the-fly setting: A12 low gives chop four, A12 high eight beats.
// - bursts wrap inside a burst-length column block chosen by upper bits.
// - one programmed length serves reads and writes alike.
// - burst length caps columns reached by one READ or WRITE.
// - mode bit 3 selects sequential or interleaved beat order.
// - chop-four sequential read rotates nibble, last four beats undriven.
// - interleaved read column is start offset XOR beat index.
// - eight-beat sequential read rotates start nibble then the other.
// - writes ignore low column bits; start at nibble or column zero.
// - chop-four bursts start internally at the same time as eight.
// - mode bit 8 starts DLL reset and then clears itself.
// - mode bits 11:9 encode write recovery of 5 to 14 clocks.
// - bit 12 low stops DLL in powerdown, slow exit; high keeps it, fast.
// - latency field sets CAS read latency 5 to 13 whole clocks.
// - READ at edge n with latency m gives first data at edge n+m.
// - mode contents persist until rewritten or reset; DLL bit self-clears.

`define DMB_MR_W          18
`define DMB_BL_LO         0
`define DMB_BL_HI         1
`define DMB_CL_EXT        2
`define DMB_BT_BIT        3
`define DMB_CL_LO         4
`define DMB_CL_HI         6
`define DMB_DLL_RST_BIT   8
`define DMB_WR_LO         9
`define DMB_WR_HI         11
`define DMB_PPD_BIT       12
`define DMB_OTF_BIT       12
`define DMB_BL_FIXED8     2'h0
`define DMB_BL_OTF        2'h1
`define DMB_BL_CHOP4      2'h2
`define DMB_MR_RESET      18'h00000
`define DMB_CL_RESET      4'h5
`define DMB_WR_RESET      4'h5
`define DMB_DLL_LOCK_CYCLES 512

`endif

//--- rtl/dmb_dll_timer.sv
/*
 * DLL lock timer: restarts on a DLL reset and reports lock after the
 * lock count. Assumes clk_en freezes it along with the rest of the block.
 */
`include "dmb_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module dmb_dll_timer #(
    parameter int LOCK_CYCLES = `DMB_DLL_LOCK_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic restart,
    output logic      locked
);
    logic [9:0] count;
    wire        done;

    assign done = (count == 10'(LOCK_CYCLES - 1));

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count  <= 10'h000;
            locked <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                count  <= 10'h000;
                locked <= 1'b0;
            end else if (!locked) begin
                count  <= count + 10'h001;
                locked <= done;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/dmb_pkg.sv
/*
 * Types shared by the base mode register block.
 * Assumes the constants header is compiled alongside.
 */
package dmb_pkg;
    typedef enum logic [1:0] {
        DMB_NOP   = 2'h0,
        DMB_MRS   = 2'h1,
        DMB_READ  = 2'h2,
        DMB_WRITE = 2'h3
    } dmb_cmd_e;

    // idle -> latency wait -> burst step one bit each; burst -> idle flips two bits
    typedef enum logic [1:0] {
        DMB_ST_IDLE  = 2'h0,
        DMB_ST_WAIT  = 2'h1,
        DMB_ST_BURST = 2'h3
    } dmb_state_e;

    typedef struct packed {
        logic        valid;
        dmb_cmd_e    kind;
        logic [17:0] addr;
    } dmb_cmd_s;
endpackage

//--- rtl/dmb_top.sv
/*
 * Base mode register and burst engine of the DRAM device: takes mode set,
 * READ and WRITE commands, orders burst columns, times read latency, runs
 * the DLL reset and reports decoded mode settings.
 * Assumes the controller keeps the mode set timing and DLL wait itself.
 */
`include "dmb_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module dmb_top
    import dmb_pkg::*;
#(
    parameter int DATA_W   = 8,
    parameter int COL_BITS = 6
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire dmb_cmd_s          cmd,
    input  wire logic              powerdown,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_data_valid,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_data_oe_n,
    output logic                   rd_strobe,
    output logic                   rd_strobe_oe_n,
    output logic      [3:0]        cas_read_latency,
    output logic      [3:0]        write_recovery_time,
    output logic                   burst_interleaved,
    output logic      [1:0]        burst_len_mode,
    output logic                   dll_locked,
    output logic                   dll_stopped,
    output logic                   slow_powerdown_exit_wait,
    output logic                   busy
);
    localparam int DEPTH = 1 << COL_BITS;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // latency code uses bits 6:4 plus the extension bit; 1..9 -> 5..13
    function automatic logic [3:0] cl_decode(input logic [3:0] code,
                                             input logic [3:0] keep);
        if (code >= 4'h1 && code <= 4'h9)
            cl_decode = code + 4'h4;
        else
            cl_decode = keep;
    endfunction

    function automatic logic [3:0] wr_decode(input logic [2:0] code);
        case (code)
            3'h1:    wr_decode = 4'h5;
            3'h2:    wr_decode = 4'h6;
            3'h3:    wr_decode = 4'h7;
            3'h4:    wr_decode = 4'h8;
            3'h5:    wr_decode = 4'hA;
            3'h6:    wr_decode = 4'hC;
            3'h7:    wr_decode = 4'hE;
            default: wr_decode = `DMB_WR_RESET;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [`DMB_MR_W-1:0] base_mode_register;
    dmb_state_e           state;
    logic                 op_read;
    logic                 chop;
    logic [2:0]           start_col;
    logic [COL_BITS-4:0]  block;
    logic [2:0]           beat;
    logic [3:0]           lat_cnt;
    logic [DATA_W-1:0]    mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // command decode

    wire       idle      = (state == DMB_ST_IDLE);
    wire       take      = cmd.valid && idle;
    wire       do_mrs    = take && (cmd.kind == DMB_MRS);
    wire       do_read   = take && (cmd.kind == DMB_READ);
    wire       do_write  = take && (cmd.kind == DMB_WRITE);
    wire       do_access = do_read || do_write;
    wire [1:0] bl_field  = base_mode_register[`DMB_BL_HI:`DMB_BL_LO];

    // one length setting steers both directions; otf follows A12
    wire cmd_chop = (bl_field == `DMB_BL_CHOP4) ||
                    ((bl_field == `DMB_BL_OTF) && !cmd.addr[`DMB_OTF_BIT]);

    wire [3:0] new_cl = cl_decode({cmd.addr[`DMB_CL_EXT],
                                   cmd.addr[`DMB_CL_HI:`DMB_CL_LO]},
                                  cas_read_latency);
    wire [3:0] new_wr = wr_decode(cmd.addr[`DMB_WR_HI:`DMB_WR_LO]);
    wire       dll_restart = do_mrs && cmd.addr[`DMB_DLL_RST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // burst timing

    // a chopped burst still occupies all eight slots, same start as eight
    wire       lat_hit   = (state == DMB_ST_WAIT) && (lat_cnt == 4'h1);
    wire       rd_emit   = lat_hit || ((state == DMB_ST_BURST) && op_read);
    wire [2:0] emit_beat = lat_hit ? 3'h0 : beat;
    wire       rd_drive  = rd_emit && !(chop && emit_beat[2]);
    wire       wr_take   = (state == DMB_ST_BURST) && !op_read && wr_data_valid;
    wire       wr_store  = wr_take && !(chop && beat[2]);
    wire       last_beat = (beat == 3'h7);
    wire [2:0] col_lo;

    // block bits stay fixed, only the low three wrap
    wire [COL_BITS-1:0] mem_idx = {block, col_lo};

    dmb_col_order u_order (
        .start_col  (start_col),
        .beat       (op_read ? emit_beat : beat),
        .interleave (burst_interleaved),
        .is_write   (!op_read),
        .chop       (chop),
        .col        (col_lo)
    );

    dmb_dll_timer #(
        .LOCK_CYCLES (`DMB_DLL_LOCK_CYCLES)
    ) u_dll (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .restart (dll_restart),
        .locked  (dll_locked)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    dmb_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            DMB_ST_IDLE: begin
                if (do_read)
                    next_state = DMB_ST_WAIT;
                else if (do_write)
                    next_state = DMB_ST_BURST;
            end
            DMB_ST_WAIT: begin
                if (lat_hit)
                    next_state = DMB_ST_BURST;
            end
            DMB_ST_BURST: begin
                if (last_beat && (op_read || wr_take))
                    next_state = DMB_ST_IDLE;
            end
            default: next_state = DMB_ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // mode register

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            base_mode_register <= `DMB_MR_RESET;
        end else if (clk_en) begin
            if (do_mrs)
                base_mode_register <= cmd.addr;
            else if (base_mode_register[`DMB_DLL_RST_BIT])
                base_mode_register[`DMB_DLL_RST_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cas_read_latency    <= `DMB_CL_RESET;
            write_recovery_time <= `DMB_WR_RESET;
            burst_interleaved   <= 1'b0;
            burst_len_mode      <= `DMB_BL_FIXED8;
        end else if (clk_en && do_mrs) begin
            cas_read_latency    <= new_cl;
            write_recovery_time <= new_wr;
            burst_interleaved   <= cmd.addr[`DMB_BT_BIT];
            burst_len_mode      <= cmd.addr[`DMB_BL_HI:`DMB_BL_LO];
        end
    end

    // dll stops only while powered down with the slow-exit setting
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dll_stopped              <= 1'b0;
            slow_powerdown_exit_wait <= 1'b1;
        end else if (clk_en) begin
            dll_stopped              <= powerdown && !base_mode_register[`DMB_PPD_BIT];
            slow_powerdown_exit_wait <= !base_mode_register[`DMB_PPD_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // burst control

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state     <= DMB_ST_IDLE;
            op_read   <= 1'b0;
            chop      <= 1'b0;
            start_col <= 3'h0;
            block     <= '0;
            lat_cnt   <= 4'h0;
            busy      <= 1'b0;
        end else if (clk_en) begin
            state <= next_state;
            busy  <= (next_state != DMB_ST_IDLE);
            if (do_access) begin
                op_read   <= do_read;
                chop      <= cmd_chop;
                start_col <= cmd.addr[2:0];
                block     <= cmd.addr[COL_BITS-1:3];
                lat_cnt   <= cas_read_latency;
            end else if (state == DMB_ST_WAIT) begin
                lat_cnt <= lat_cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            beat <= 3'h0;
        end else if (clk_en) begin
            if (do_access)
                beat <= 3'h0;
            else if (lat_hit || (rd_emit && !lat_hit) || wr_take)
                beat <= beat + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage and read drivers

    // storage has no reset; contents survive like the real array
    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_store)
            mem[mem_idx] <= wr_data;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_data        <= '0;
            rd_data_oe_n   <= 1'b1;
            rd_strobe      <= 1'b0;
            rd_strobe_oe_n <= 1'b1;
        end else if (clk_en) begin
            rd_data        <= rd_drive ? mem[mem_idx] : '0;
            rd_data_oe_n   <= !rd_drive;
            rd_strobe      <= rd_drive && !emit_beat[0];
            rd_strobe_oe_n <= !rd_drive;
        end
    end
endmodule
`default_nettype wire

//--- test/dmb_ctl_model.sv
/* Memory controller model: mode set, READ and WRITE commands.
   Assumes the bench calls its tasks and waits for burst ends itself. */
`timescale 1ns/1ns
`default_nettype none
module dmb_ctl_model
    import dmb_pkg::*;
#(
    parameter int MOD_WAIT = 4
) (
    input  wire logic       clk_sys,
    output var  dmb_cmd_s   cmd,
    output logic      [7:0] wr_data,
    output logic            wr_data_valid
);
initial begin
    cmd = '0;
    wr_data = 8'h00;
    wr_data_valid = 1'b0;
end
// released bus shows the inverse, never a stale copy
task automatic issue(input dmb_cmd_e k, input logic [17:0] a, input int gap);
    @(posedge clk_sys);
    cmd <= '{valid: 1'b1, kind: k, addr: a};
    @(posedge clk_sys);
    cmd <= '{valid: 1'b0, kind: DMB_NOP, addr: ~a};
    repeat (gap) @(posedge clk_sys);
endtask
// reserved bits 7, 13, 14 and 17 forced low, 15 and 16 passed, every field sent, update delay kept
task automatic mrs(input logic [17:0] v);
    issue(DMB_MRS, v & 18'h19F7F, MOD_WAIT);
endtask
task automatic wr(input logic [17:0] a, input logic [7:0] base);
    issue(DMB_WRITE, a, 0);
    for (int b = 0; b < 8; b++) begin
        wr_data <= base + 8'(b);
        wr_data_valid <= 1'b1;
        @(posedge clk_sys);
    end
    wr_data <= ~wr_data;
    wr_data_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
endtask
endmodule
`default_nettype wire

//--- test/dmb_top_properties.sv
/* Port assertions for the base mode register block.
   Assumes binding onto every dmb_top instance. */
`timescale 1ns/1ns
`default_nettype none
module dmb_chk
    import dmb_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       clk_en,
    input wire dmb_cmd_s   cmd,
    input wire logic       powerdown,
    input wire logic [3:0] cas_read_latency,
    input wire logic [3:0] write_recovery_time,
    input wire logic       burst_interleaved,
    input wire logic [1:0] burst_len_mode,
    input wire logic       dll_locked,
    input wire logic       dll_stopped,
    input wire logic       slow_powerdown_exit_wait,
    input wire logic       busy,
    input wire logic       rd_data_oe_n,
    input wire logic       rd_strobe,
    input wire logic       rd_strobe_oe_n
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!reset_n);
wire take = clk_en && cmd.valid && !busy;
wire mrs  = take && cmd.kind == DMB_MRS;
////////////////////////////////////////////////////////////////////////////////
property p_len; mrs |=> burst_len_mode == $past(cmd.addr[1:0]); endproperty
a_len: assert property (p_len) else $error("length mode not stored");
property p_type; mrs |=> burst_interleaved == $past(cmd.addr[3]); endproperty
a_type: assert property (p_type) else $error("burst type not stored");
// exit-wait flag follows the stored bit, so it lands one enabled cycle after it
property p_ppd;
    mrs ##1 clk_en |=> slow_powerdown_exit_wait == !$past(cmd.addr[12], 2);
endproperty
a_ppd: assert property (p_ppd) else $error("powerdown exit mode wrong");
property p_stop;
    $past(clk_en) |-> dll_stopped == ($past(powerdown) && slow_powerdown_exit_wait);
endproperty
a_stop: assert property (p_stop) else $error("dll stop state wrong");
property p_dll; mrs && cmd.addr[8] |=> !dll_locked; endproperty
a_dll: assert property (p_dll) else $error("dll reset did not drop lock");
property p_cl; cas_read_latency inside {[4'h5:4'hD]}; endproperty
a_cl: assert property (p_cl) else $error("read latency out of range");
property p_wr; write_recovery_time inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE}; endproperty
a_wr: assert property (p_wr) else $error("write recovery illegal");
property p_lat;
    take && cmd.kind == DMB_READ && cas_read_latency == 4'h5 |-> rd_data_oe_n[*6] ##1 !rd_data_oe_n;
endproperty
a_lat: assert property (p_lat) else $error("first read beat mistimed");
property p_strb; !rd_strobe_oe_n && !$past(rd_strobe_oe_n) |-> rd_strobe != $past(rd_strobe); endproperty
a_strb: assert property (p_strb) else $error("strobe did not toggle");
property p_burst; $rose(busy) |-> ##[1:40] !busy; endproperty
a_burst: assert property (p_burst) else $error("burst overran");
c_read: cover property (take && cmd.kind == DMB_READ);
c_lock: cover property ($rose(dll_locked));
c_chop: cover property (busy && rd_data_oe_n && $past(!rd_data_oe_n));
endmodule
bind dmb_top dmb_chk u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cmd(cmd),
    .powerdown(powerdown), .cas_read_latency(cas_read_latency),
    .write_recovery_time(write_recovery_time), .burst_interleaved(burst_interleaved),
    .burst_len_mode(burst_len_mode), .dll_locked(dll_locked), .dll_stopped(dll_stopped),
    .slow_powerdown_exit_wait(slow_powerdown_exit_wait), .busy(busy),
    .rd_data_oe_n(rd_data_oe_n), .rd_strobe(rd_strobe), .rd_strobe_oe_n(rd_strobe_oe_n)
);
`default_nettype wire

//--- test/dmb_top_tb.sv
/* Self-checking bench for the base mode register block.
   Assumes the controller model and the bound checker are compiled too. */
`timescale 1ns/1ns
`default_nettype none
module dmb_top_tb
    import dmb_pkg::*;
;
logic       clk_sys, reset_n, clk_en, powerdown;
dmb_cmd_s   cmd;
logic [7:0] wd, rd_data;
logic       wv, rd_data_oe_n, rd_strobe, sto_n, il, locked, stopped, slow, busy;
logic [3:0] cl, wrt;
logic [1:0] blm;
int         err_count = 0, samples_checked = 0, cycles = 0;
dmb_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .cmd(cmd),
    .powerdown(powerdown), .wr_data(wd), .wr_data_valid(wv), .rd_data(rd_data),
    .rd_data_oe_n(rd_data_oe_n), .rd_strobe(rd_strobe), .rd_strobe_oe_n(sto_n),
    .cas_read_latency(cl), .write_recovery_time(wrt), .burst_interleaved(il),
    .burst_len_mode(blm), .dll_locked(locked), .dll_stopped(stopped),
    .slow_powerdown_exit_wait(slow), .busy(busy));
dmb_ctl_model ctl (.clk_sys(clk_sys), .cmd(cmd), .wr_data(wd), .wr_data_valid(wv));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
        err_count++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
function automatic logic [2:0] ecol(input logic [2:0] s, input logic [2:0] b, input logic i);
    return i ? s ^ b : {s[2] ^ b[2], s[1:0] + b[1:0]};
endfunction
// block 0 holds A0+col; block 1 holds C0.. low nibble, B0.. high nibble
task automatic rd_chk(input logic [5:0] col, input logic a12, input logic i, input logic ch);
    int n;
    logic [5:0] e;
    n = 0;
    ctl.issue(DMB_READ, {5'h00, a12, 6'h00, col}, 0);
    while (rd_data_oe_n && n < 20) begin
        @(posedge clk_sys);
        #1;
        n++;
    end
    chk(8'(n), 8'h05);
    for (int b = 0; b < 8; b++) begin
        e = {col[5:3], ecol(col[2:0], 3'(b), i)};
        chk({rd_data_oe_n, sto_n}, (ch && b > 3) ? 8'h03 : 8'h00);
        if (!(ch && b > 3)) begin
            chk(rd_data, e[3] ? (e[2] ? 8'hB0 : 8'hC0) + e[1:0] : 8'hA0 + e[2:0]);
            chk(rd_strobe, !b[0]);
        end
        @(posedge clk_sys);
        #1;
    end
    while (busy) @(posedge clk_sys);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    @(posedge clk_sys);
    #1;
    chk({cl, wrt}, 8'h55);
    chk({il, blm, locked, stopped, slow, busy, rd_data_oe_n}, 8'h05);
endtask
task automatic t_decode;
    logic [3:0] wtab [8] = '{4'h5, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};
    logic [3:0] c;
    for (int i = 1; i < 11; i++) begin
        c = (i == 10) ? 4'h0 : 4'(i);
        ctl.mrs({5'h00, i[0], 3'(i), 2'h0, c[2:0], i[1], c[3], 2'(i % 3)});
        #1;
        chk(cl, (i == 10) ? 4'hD : 4'(i + 4));
        chk(wrt, wtab[i % 8]);
        chk({il, blm, slow}, {i[1], 2'(i % 3), !i[0]});
        @(posedge clk_sys);
        powerdown <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(stopped, !i[0]);
        @(posedge clk_sys);
        powerdown <= 1'b0;
    end
endtask
task automatic t_dll;
    int n;
    n = 0;
    ctl.issue(DMB_MRS, 18'h00110, 0);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (30) @(posedge clk_sys);
    clk_en <= 1'b1;
    #1;
    chk(locked, 1'b0);
    while (!locked && n < 700) begin
        @(posedge clk_sys);
        #1;
        n++;
    end
    // 512 enabled edges in all; one of them ran before the freeze
    chk(n == 511, 1'b1);
endtask
task automatic t_order;
    ctl.wr(18'h00000, 8'hA0);
    ctl.wr(18'h0000B, 8'hC0);
    for (int m = 0; m < 6; m++) begin
        ctl.mrs({11'h000, 3'h1, m[0], 1'b0, (m < 2) ? 2'h0 : (m < 4) ? 2'h2 : 2'h1});
        chk(locked, 1'b1);
        for (int s = 0; s < 8; s++) begin
            rd_chk(6'(s), m == 5, m[0], m inside {2, 3, 4});
        end
    end
endtask
task automatic t_chop_wr;
    ctl.mrs(18'h00012);
    ctl.wr(18'h0000D, 8'hB0);
    ctl.mrs(18'h00010);
    rd_chk(6'd12, 1'b0, 1'b0, 1'b0);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
        err_count++;
        complete_run();
    end
end
initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    powerdown = 1'b0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_decode();
    t_dll();
    t_order();
    t_chop_wr();
    ctl.mrs(18'h00E1D);
    chk({cl, wrt}, 8'hDE);
    // mid-run reset must bring every decoded setting back and drop the lock
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    complete_run();
end
endmodule
`default_nettype wire
